// ===== verilog/lane_map.sv
// Purpose: Sample-to-lane mapping, lane set, power-down and test select.
// Assumes: Samples arrive as a block on hclk; serializers follow.
// Notes: Words are left aligned; unused low bits are zero.
`timescale 1ns/1ps
module lane_map
   import lane_pkg::*;
#(
   parameter int FLUSH_CYCLES = 64
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic power_down_pin,
   input wire logic in_valid,
   input wire sample_blk_t samples,
   output lane_bus_t lanes,
   output logic out_valid,
   output logic crc12_en,
   output logic fec_en,
   output logic bypass_link,
   output logic link_reinit,
   output logic [1:0] pair_on
);
   localparam logic [15:0] FLUSH_LEN = 16'(FLUSH_CYCLES);
   localparam logic [15:0] ONE16 = 16'h0001;

   ctrl_t ctrl;
   pwr_state_t pwr;
   pwr_state_t next_pwr;
   logic [15:0] flush_cnt;
   logic pd_meta;
   logic pd_sync;
   logic pd_req;
   logic ap_act;
   logic ap_wr;
   logic [AW-1:0] ap_addr;
   logic alt_on;
   logic prbs_on;
   lane_word_t [LANES-1:0] mapped;
   lane_word_t [LANES-1:0] prbs_word;
   lane_word_t [LANES-1:0] next_word;
   logic [LANES-1:0] next_drive_en;

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
      return a == off;
   endfunction : hit

   function automatic lane_word_t map_lane(input sample_blk_t b, input logic [3:0] m,
                                           input int k);
      int c;
      int i;
      c = k / HALF;
      i = k % HALF;
      case (m)
         MODE12: return {b.s[c][i][SW-1 -: W8], {(WW-W8){1'b0}}}; // see RULE1
         MODE13: return {b.s[c][i][SW-1 -: W10], b.s[c][i+HALF][SW-1 -: W10],
                         b.s[c][i+2*HALF][SW-1 -: W10],
                         b.s[c][i+3*HALF][SW-1 -: W10]}; // see RULE2
         MODE14: return {b.s[k/2][k%2], b.s[k/2][k%2+2], {(WW-2*SW){1'b0}}}; // see RULE3
         MODE15: return {b.s[c][i], b.s[c][i+HALF], {(WW-2*SW){1'b0}}}; // see RULE4
         default: return '0;
      endcase
   endfunction : map_lane

   // The first flop only feeds the second; the pin is asynchronous.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_meta <= 1'b0;
         pd_sync <= 1'b0;
      end else if (ce) begin
         pd_meta <= power_down_pin;
         pd_sync <= pd_meta;
      end
   end

   assign pd_req = pd_sync | ctrl.pd; // see RULE10 see RULE11

   // AHB-Lite address phase capture.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_act <= 1'b0;
         ap_wr <= 1'b0;
         ap_addr <= '0;
      end else if (ce && hready) begin
         ap_act <= hsel & htrans[1];
         ap_wr <= hwrite;
         ap_addr <= haddr[AW-1:0];
      end
   end

   // Settings are only touched by reset or a bus write, never by power-down.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RST;
      end else if (ce && ap_act && ap_wr && hit(ap_addr, CTRL_OFF)) begin
         ctrl <= hwdata & CTRL_WMASK; // see RULE12
      end
   end

   // Read data is registered in the address phase; unmapped reads give zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
         if (hit(haddr[AW-1:0], CTRL_OFF)) begin
            hrdata <= ctrl;
         end else if (hit(haddr[AW-1:0], STAT_OFF)) begin
            hrdata <= {24'h0, lanes.drive_en[HALF-1:0] == '0 && alt_on,
                       ctrl.lane_four, alt_on, prbs_on, out_valid, pd_sync,
                       pwr};
         end else begin
            hrdata <= '0;
         end
      end
   end

   assign hreadyout = ce;
   assign hresp = 1'b0;

   always_comb begin
      next_pwr = pwr;
      unique case (pwr)
         PWR_RUN: if (pd_req) next_pwr = PWR_DOWN;
         PWR_DOWN: if (!pd_req) next_pwr = PWR_FLUSH;
         PWR_FLUSH: begin
            if (pd_req) begin
               next_pwr = PWR_DOWN;
            end else if (flush_cnt == ONE16) begin
               next_pwr = PWR_RUN;
            end
         end
         default: next_pwr = PWR_DOWN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr <= PWR_RUN;
      end else if (ce) begin
         pwr <= next_pwr;
      end
   end

   // Stale pipeline contents are held back for the flush time.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flush_cnt <= '0;
      end else if (ce) begin
         if (pwr == PWR_DOWN) begin
            flush_cnt <= FLUSH_LEN; // see RULE13
         end else if (pwr == PWR_FLUSH) begin
            flush_cnt <= flush_cnt - ONE16;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_reinit <= 1'b0;
      end else if (ce) begin
         link_reinit <= pwr == PWR_DOWN && next_pwr == PWR_FLUSH; // see RULE13
      end
   end

   assign alt_on = ctrl.lane_set_select & ctrl.lane_four; // see RULE7
   assign prbs_on = ctrl.link_test_select != TEST_OFF && pwr != PWR_DOWN;

   generate
      for (genvar k = 0; k < LANES; k++) begin : g_lane
         localparam int SRC = (k >= HALF) ? k - HALF : k;
         assign mapped[k] = map_lane(samples, ctrl.link_mode_select, k);
         prbs_lane #(
            .SEED(SEED_BASE + HW'(k))
         ) u_prbs (
            .hclk(hclk),
            .hresetn(hresetn),
            .ce(ce),
            .run(prbs_on),
            .order(ctrl.link_test_select),
            .word(prbs_word[k])
         );
         always_comb begin
            if (prbs_on) begin
               next_word[k] = prbs_word[k]; // see RULE17
            end else if (alt_on) begin
               next_word[k] = (k >= HALF) ? mapped[SRC] : '0; // see RULE8
            end else begin
               next_word[k] = mapped[k]; // see RULE21
            end
         end
      end
   endgenerate

   // Lane count depends on lane_four and the power state only, whatever the test select.
   always_comb begin
      if (pwr == PWR_DOWN) begin
         next_drive_en = '0; // see RULE10
      end else if (ctrl.lane_four) begin
         next_drive_en = alt_on ? SET_HI : SET_LO; // see RULE9 see RULE15
      end else begin
         next_drive_en = SET_ALL;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lanes <= '0;
         out_valid <= 1'b0;
      end else if (ce) begin
         lanes.drive_en <= next_drive_en;
         lanes.word <= next_word;
         out_valid <= pwr == PWR_RUN && next_pwr == PWR_RUN && (prbs_on || in_valid);
      end
   end

   // Only CRC-12 or FEC is selected on the header stream, so CRC-3 cannot occur.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         crc12_en <= 1'b0;
         fec_en <= 1'b0;
         bypass_link <= 1'b0;
         pair_on <= '0;
      end else if (ce) begin
         crc12_en <= !ctrl.fec && !prbs_on; // see RULE5
         fec_en <= ctrl.fec && !prbs_on; // see RULE6
         bypass_link <= prbs_on; // see RULE17
         pair_on <= (pwr == PWR_DOWN) ? 2'b00 : ctrl.channel_pair_enable;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_pd_drivers;
      ce && pd_sync ##1 ce |=> lanes.drive_en == '0;
   endproperty
   a_pd_drivers: assert property (p_pd_drivers) else $error("drivers on in power-down"); // RULE10

   property p_mode_pd;
      ce && ctrl.pd && pwr == PWR_RUN |=> ce |-> ##1 (lanes.drive_en == '0);
   endproperty
   a_mode_pd: assert property (p_mode_pd) else $error("mode power-down ignored"); // RULE11

   property p_one_set;
      ce && ctrl.lane_four |=> !(|lanes.drive_en[HALF-1:0] && |lanes.drive_en[LANES-1:HALF]);
   endproperty
   a_one_set: assert property (p_one_set) else $error("both lane sets driven"); // RULE9

   property p_alt_four;
      ce && !(ctrl.lane_four && ctrl.lane_set_select) |=> lanes.drive_en != SET_HI;
   endproperty
   a_alt_four: assert property (p_alt_four) else $error("alternate set without four lanes"); // RULE7

   property p_alt_copy;
      ce && alt_on && !prbs_on |=> lanes.word[HALF] == $past(mapped[0]);
   endproperty
   a_alt_copy: assert property (p_alt_copy) else $error("alternate lane data wrong"); // RULE8

   property p_crc_only;
      ce && !prbs_on |=> crc12_en != fec_en;
   endproperty
   a_crc_only: assert property (p_crc_only) else $error("header check mode wrong"); // RULE5

   property p_fec;
      ce && ctrl.fec && !prbs_on |=> fec_en && !crc12_en;
   endproperty
   a_fec: assert property (p_fec) else $error("fec not selected"); // RULE6

   property p_keep_ctrl;
      $rose(pd_sync) && !(ap_act && ap_wr) |=> $stable(ctrl);
   endproperty
   a_keep_ctrl: assert property (p_keep_ctrl) else $error("settings lost in power-down"); // RULE12

   property p_flush;
      ce && pwr == PWR_DOWN && next_pwr == PWR_FLUSH |=> !out_valid [*8];
   endproperty
   a_flush: assert property (p_flush) else $error("data valid during flush"); // RULE13

   property p_relink;
      ce && link_reinit |=> !link_reinit;
   endproperty
   a_relink: assert property (p_relink) else $error("relink pulse too long"); // RULE13

   property p_valid_down;
      ce && pwr == PWR_DOWN |=> !out_valid;
   endproperty
   a_valid_down: assert property (p_valid_down) else $error("data valid while down"); // RULE10

   property p_pair_down;
      ce && pwr == PWR_DOWN |=> pair_on == '0;
   endproperty
   a_pair_down: assert property (p_pair_down) else $error("channel pairs on while down"); // RULE10

   property p_mode12;
      ce && ctrl.link_mode_select == MODE12 && !prbs_on && !alt_on
      |=> lanes.word[1][WW-1 -: W8] == $past(samples.s[0][1][SW-1 -: W8]);
   endproperty
   a_mode12: assert property (p_mode12) else $error("mode 12 map wrong"); // RULE1

   property p_mode13;
      ce && ctrl.link_mode_select == MODE13 && !prbs_on && !alt_on
      |=> lanes.word[5][W10-1:0] == $past(samples.s[1][13][SW-1 -: W10]);
   endproperty
   a_mode13: assert property (p_mode13) else $error("mode 13 map wrong"); // RULE2

   property p_mode14;
      ce && ctrl.link_mode_select == MODE14 && !prbs_on && !alt_on
      |=> lanes.word[3][WW-1 -: 2*SW] == $past({samples.s[1][1], samples.s[1][3]});
   endproperty
   a_mode14: assert property (p_mode14) else $error("mode 14 map wrong"); // RULE3

   property p_mode15;
      ce && ctrl.link_mode_select == MODE15 && !prbs_on && !alt_on
      |=> lanes.word[6][WW-1 -: 2*SW] == $past({samples.s[1][2], samples.s[1][6]});
   endproperty
   a_mode15: assert property (p_mode15) else $error("mode 15 map wrong"); // RULE4

   property p_test_lanes;
      ce && prbs_on && !ctrl.lane_four |=> lanes.drive_en == SET_ALL;
   endproperty
   a_test_lanes: assert property (p_test_lanes) else $error("test changed lane count"); // RULE15

   property p_bypass;
      ce && prbs_on |=> bypass_link && lanes.word[0] == $past(prbs_word[0]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("prbs not bypassing link"); // RULE17

   property p_phase;
      ce && prbs_on |=> lanes.word[0] != lanes.word[1];
   endproperty
   a_phase: assert property (p_phase) else $error("two lanes share a phase"); // RULE19

   c_mode13: cover property (out_valid && ctrl.link_mode_select == MODE13);
   c_alt: cover property (out_valid && lanes.drive_en == SET_HI);
   c_prbs31: cover property (bypass_link && ctrl.link_test_select == PRBS31);
   c_relink: cover property (link_reinit ##[1:100] out_valid);
endmodule : lane_map

// ===== verilog/lane_pkg.sv
// Purpose: Shared constants and types for the serial lane mapper.
// Assumes: One 40 MHz clock; registers reached over AHB-Lite.
// Notes: Contract
// Contract
// RULE1: Mode 12 puts one 8-bit sample per lane.
// RULE2: Mode 13 packs four 10-bit samples per lane.
// RULE3: Mode 14 lane pairs carry channels A to D.
// RULE4: Mode 15 lane k carries samples k, k+4.
// RULE5: Only CRC-12 is offered, never CRC-3.
// RULE6: FEC is selectable instead of CRC-12.
// RULE7: Redundant lanes only with four lanes or fewer.
// RULE8: Lane set select picks D3-D0 or D7-D4.
// RULE9: Never drive both lane sets at once.
// RULE10: Power-down pin disables all serial drivers.
// RULE11: Mode setting can also request full power-down.
// RULE12: Settings survive power-down unchanged.
// RULE13: After power-down, relink and flush stale data.
// RULE14: Pair enable must not power down everything.
// RULE15: Lane count follows link mode in tests.
// RULE16: Enable test patterns only with link disabled.
// RULE17: Pseudo-random modes bypass scrambling and encoding.
// RULE18: Each bit is XOR of two tapped bits.
// RULE19: Every lane starts from a distinct phase.
// RULE20: Receiver self-synchronises to the random pattern.
// RULE21: Samples packed MSB first without gaps.
package lane_pkg;
   localparam int LANES = 8;
   localparam int HALF = 4;
   localparam int NCH = 4;
   localparam int NSAMP = 16;
   localparam int SW = 12;
   localparam int WW = 40;
   localparam int W8 = 8;
   localparam int W10 = 10;
   localparam int HW = 31;
   localparam int AW = 8;
   typedef logic [SW-1:0] sample_t;
   typedef logic [WW-1:0] lane_word_t;
   typedef struct packed {
      sample_t [NCH-1:0][NSAMP-1:0] s;
   } sample_blk_t;
   typedef struct packed {
      logic [LANES-1:0] drive_en;
      lane_word_t [LANES-1:0] word;
   } lane_bus_t;
   typedef enum logic [3:0] {
      MODE12 = 4'hc,
      MODE13 = 4'hd,
      MODE14 = 4'he,
      MODE15 = 4'hf
   } link_mode_t;
   typedef enum logic [2:0] {
      TEST_OFF = 3'h0,
      PRBS7 = 3'h1,
      PRBS9 = 3'h2,
      PRBS15 = 3'h3,
      PRBS23 = 3'h4,
      PRBS31 = 3'h5
   } test_sel_t;
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_DOWN = 2'b01,
      PWR_FLUSH = 2'b10
   } pwr_state_t;
   typedef struct packed {
      logic [13:0] rsvd_hi;
      logic [1:0] channel_pair_enable;
      logic [2:0] link_test_select;
      logic lane_four;
      logic pd;
      logic fec;
      logic lane_set_select;
      logic [4:0] rsvd_lo;
      logic [3:0] link_mode_select;
   } ctrl_t;
   localparam logic [AW-1:0] CTRL_OFF = 8'h00;
   localparam logic [AW-1:0] STAT_OFF = 8'h04;
   localparam logic [31:0] CTRL_WMASK = 32'h0003_fe0f;
   localparam logic [31:0] CTRL_RST = 32'h0003_000c;
   localparam logic [LANES-1:0] SET_LO = 8'h0f;
   localparam logic [LANES-1:0] SET_HI = 8'hf0;
   localparam logic [LANES-1:0] SET_ALL = 8'hff;
   localparam logic [HW-1:0] SEED_BASE = 31'h0000_0001;
endpackage : lane_pkg

// ===== verilog/prbs_lane.sv
// Purpose: One lane's pseudo-random generator, forty bits per clock.
// Assumes: The order select is stable while run is high.
// Notes: Word bit 39 is the oldest bit of the cycle.
`timescale 1ns/1ps
module prbs_lane
   import lane_pkg::*;
#(
   parameter logic [HW-1:0] SEED = SEED_BASE
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic [2:0] order,
   output lane_word_t word
);
   logic [HW-1:0] hist;
   logic [HW-1:0] next_hist;

   function automatic int tap_a(input logic [2:0] o);
      case (o)
         PRBS9: return 5;
         PRBS15: return 14;
         PRBS23: return 18;
         PRBS31: return 28;
         default: return 6;
      endcase
   endfunction : tap_a

   function automatic int tap_b(input logic [2:0] o);
      case (o)
         PRBS9: return 9;
         PRBS15: return 15;
         PRBS23: return 23;
         PRBS31: return 31;
         default: return 7;
      endcase
   endfunction : tap_b

   always_comb begin
      logic b;
      b = 1'b0;
      next_hist = hist;
      word = '0;
      for (int i = 0; i < WW; i++) begin
         b = next_hist[tap_a(order)-1] ^ next_hist[tap_b(order)-1]; // see RULE18
         next_hist = {next_hist[HW-2:0], b};
         word[WW-1-i] = b;
      end
   end

   // Reloading the seed while idle keeps each lane's phase distinct.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hist <= SEED;
      end else if (ce) begin
         hist <= run ? next_hist : SEED; // see RULE19
      end
   end

   property p_prbs7_recur;
      @(posedge hclk) disable iff (!hresetn)
      (order == PRBS7) |-> word[WW-8] == (word[WW-2] ^ word[WW-1]);
   endproperty
   a_prbs7_recur: assert property (p_prbs7_recur) else $error("prbs7 recursion broken"); // RULE18
endmodule : prbs_lane

// ===== sim/prbs_rx_model.sv
// Purpose: Receiver-side model that self-synchronises to lane 0 test patterns.
// Assumes: The order select is changed only while the bypass is off.
// Notes: Words are taken oldest bit first, bit 39 down to bit 0.
`timescale 1ns/1ps
module prbs_rx_model
   import lane_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire lane_bus_t lanes,
   input wire logic out_valid,
   input wire logic bypass_link,
   input wire logic [2:0] sel,
   output int bad,
   output int good
);
   int ta;
   int tb;
   logic [HW-1:0] hist;
   int seen;
   always_comb begin
      case (sel)
         3'h1: begin ta = 6; tb = 7; end
         3'h2: begin ta = 5; tb = 9; end
         3'h3: begin ta = 14; tb = 15; end
         3'h4: begin ta = 18; tb = 23; end
         default: begin ta = 28; tb = 31; end
      endcase
   end
   // No phase is assumed: checking starts once enough history is held.
   always @(posedge hclk or negedge hresetn) begin : rx
      logic [HW-1:0] h;
      int n;
      logic b;
      if (!hresetn) begin
         hist <= '0;
         seen <= 0;
         bad <= 0;
         good <= 0;
      end else if (out_valid && bypass_link) begin
         h = hist;
         n = seen;
         for (int i = 39; i >= 0; i--) begin
            b = lanes.word[0][i];
            if (n >= tb) begin
               if (b !== (h[ta-1] ^ h[tb-1])) bad <= bad + 1;
               else good <= good + 1;
            end
            h = {h[HW-2:0], b};
            n = n + 1;
         end
         hist <= h;
         seen <= n;
      end else begin
         seen <= 0;
      end
   end
endmodule : prbs_rx_model

// ===== sim/test_serdes_lane_map_and_test_patterns.sv
// Purpose: Self-checking bench for the lane mapper.
// Assumes: ce is held high and hready is looped back from hreadyout.
// Notes: The flush count is cut to 8 so that power-down recovery stays short.
`timescale 1ns/1ps
module test_serdes_lane_map_and_test_patterns;
   import lane_pkg::*;
   localparam int FLUSH = 8;
   logic hclk, hresetn, ce, hsel, hwrite, power_down_pin, in_valid;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, pair_on;
   logic [2:0] hsize, sel;
   wire logic hready;
   logic hreadyout, hresp, out_valid, crc12_en, fec_en, bypass_link, link_reinit;
   sample_blk_t samples;
   lane_bus_t lanes;
   int bad, good, error_cnt, check_count, cycles, g0;
   assign hready = hreadyout;
   lane_map #(.FLUSH_CYCLES(FLUSH)) lane_map_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .power_down_pin(power_down_pin), .in_valid(in_valid),
      .samples(samples), .lanes(lanes), .out_valid(out_valid), .crc12_en(crc12_en),
      .fec_en(fec_en), .bypass_link(bypass_link), .link_reinit(link_reinit),
      .pair_on(pair_on));
   prbs_rx_model prbs_rx_model_i (.hclk(hclk), .hresetn(hresetn), .lanes(lanes),
      .out_valid(out_valid), .bypass_link(bypass_link), .sel(sel), .bad(bad), .good(good));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         final_report;
      end
   end
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // The request is held until hready is seen high, so no wait state is assumed.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      hsel <= 1'b1;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : bus
   function automatic lane_word_t exp_word(input int m, input int k);
      int c;
      int i;
      c = k / 4;
      i = k % 4;
      case (m)
         12: return {samples.s[c][i][11:4], 32'h0};
         13: return {samples.s[c][i][11:2], samples.s[c][i+4][11:2],
                     samples.s[c][i+8][11:2], samples.s[c][i+12][11:2]};
         14: return {samples.s[k/2][k%2], samples.s[k/2][k%2+2], 16'h0};
         default: return {samples.s[c][i], samples.s[c][i+4], 16'h0};
      endcase
   endfunction : exp_word
   task automatic t_reset;
      bus(1'b0, 32'h0000_0000, 32'h0);
      chk("ctrl reset", CTRL_RST, q);
      bus(1'b1, 32'h0000_0008, 32'hffff_ffff);
      bus(1'b0, 32'h0000_0008, 32'h0);
      chk("unmapped read", 40'h0, q);
      bus(1'b0, 32'h0000_0000, 32'h0);
      chk("ctrl after unmapped write", CTRL_RST, q);
      chk("crc12", 40'h1, crc12_en);
      chk("hresp okay", 40'h0, hresp);
   endtask : t_reset
   task automatic t_map;
      for (int m = 12; m <= 15; m++) begin
         bus(1'b1, 32'h0, (CTRL_RST & ~32'hf) | m);
         bus(1'b0, 32'h0, 32'h0);
         chk("ctrl readback", (CTRL_RST & ~32'hf) | m, q);
         repeat (3) @(posedge hclk);
         for (int k = 0; k < LANES; k++) begin
            chk("lane word", exp_word(m, k), lanes.word[k]);
         end
         chk("out valid", 40'h1, out_valid);
      end
      bus(1'b1, 32'h0, CTRL_RST);
   endtask : t_map
   task automatic t_fec;
      bus(1'b1, 32'h0, CTRL_RST | 32'h400);
      repeat (3) @(posedge hclk);
      chk("fec", 40'h1, fec_en);
      chk("crc12 with fec", 40'h0, crc12_en);
      bus(1'b1, 32'h0, CTRL_RST);
   endtask : t_fec
   task automatic t_alt;
      bus(1'b1, 32'h0, CTRL_RST | 32'h200);
      repeat (3) @(posedge hclk);
      chk("set select with 8 lanes", SET_ALL, lanes.drive_en);
      bus(1'b1, 32'h0, CTRL_RST | 32'h1200);
      repeat (3) @(posedge hclk);
      chk("alternate set", SET_HI, lanes.drive_en);
      chk("alternate lane data", exp_word(12, 0), lanes.word[HALF]);
      chk("default lane idle", 40'h0, lanes.word[0]);
      bus(1'b1, 32'h0, CTRL_RST | 32'h1000);
      repeat (3) @(posedge hclk);
      chk("default set", SET_LO, lanes.drive_en);
      bus(1'b1, 32'h0, CTRL_RST);
   endtask : t_alt
   task automatic t_pd;
      int n;
      bus(1'b1, 32'h0, CTRL_RST | 32'h400);
      power_down_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("drivers in power-down", 40'h0, lanes.drive_en);
      chk("valid in power-down", 40'h0, out_valid);
      power_down_pin <= 1'b0;
      n = 0;
      while (link_reinit !== 1'b1 && n < 10) begin
         @(posedge hclk);
         n++;
      end
      chk("relink pulse", 40'h1, link_reinit);
      chk("valid during flush", 40'h0, out_valid);
      repeat (FLUSH + 4) @(posedge hclk);
      chk("valid after flush", 40'h1, out_valid);
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl kept", CTRL_RST | 32'h400, q);
      bus(1'b1, 32'h0, CTRL_RST | 32'h800);
      repeat (6) @(posedge hclk);
      chk("drivers in mode power-down", 40'h0, lanes.drive_en);
      chk("pairs off in power-down", 40'h0, pair_on);
      bus(1'b0, 32'h4, 32'h0);
      chk("status in power-down", 40'h1, q);
      // One pair stays on: pair enables never power down everything.
      bus(1'b1, 32'h0, (CTRL_RST & ~32'h30000) | 32'h10000);
      repeat (FLUSH + 6) @(posedge hclk);
      chk("pair enable", 40'h1, pair_on);
      bus(1'b1, 32'h0, CTRL_RST);
      repeat (FLUSH + 6) @(posedge hclk);
   endtask : t_pd
   task automatic t_prbs;
      for (int t = 1; t <= 5; t++) begin
         sel <= 3'(t);
         g0 = good;
         bus(1'b1, 32'h0, CTRL_RST | (t << 13));
         repeat (12) @(posedge hclk);
         chk("bypass", 40'h1, bypass_link);
         chk("crc12 in test", 40'h0, crc12_en);
         chk("lanes in test", SET_ALL, lanes.drive_en);
         chk("lane phases differ", 40'h1, lanes.word[0] !== lanes.word[1]);
         chk("pattern checked", 40'h1, good > g0);
         // Test off between orders keeps the bypass off while sel is changed.
         bus(1'b1, 32'h0, CTRL_RST);
         repeat (3) @(posedge hclk);
      end
      chk("pattern errors", 40'h0, 40'(bad));
   endtask : t_prbs
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      power_down_pin = 1'b0;
      in_valid = 1'b1;
      sel = 3'h0;
      error_cnt = 0;
      check_count = 0;
      cycles = 0;
      for (int c = 0; c < NCH; c++) begin
         for (int i = 0; i < NSAMP; i++) begin
            samples.s[c][i] = sample_t'((c * 16 + i) * 16 + 15 - i);
         end
      end
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_map;
      t_fec;
      t_alt;
      t_pd;
      t_prbs;
      final_report;
   end
endmodule : test_serdes_lane_map_and_test_patterns
